// *** pkg/wdp_pkg.sv ***
// Shared constants and carrier types for the watchdog with postscaler.
package wdp_pkg;

  // --------------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // --------------------------------------------------------------------
  localparam int unsigned AW = 16;
  // Printed indices; the byte address is four times the index.
  localparam logic [AW-1:0] OPT_IDX  = 16'h0081;
  localparam logic [AW-1:0] CFG_IDX  = 16'h2007;
  localparam logic [AW-1:0] OPT_ADR  = 16'h0204;
  localparam logic [AW-1:0] CFG_ADR  = 16'h801C;
  localparam logic [AW-1:0] STAT_ADR = 16'h0000;
  localparam logic [AW-1:0] EVT_ADR  = 16'h0004;
  localparam logic [AW-1:0] MASK_ADR = 16'h0008;
  localparam logic [AW-1:0] CNT_ADR  = 16'h000C;

  // --------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------
  localparam int unsigned CFG_EN_BIT   = 2;
  localparam int unsigned OPT_ASSIGN   = 3;
  localparam int unsigned EVT_RESET    = 0;
  localparam int unsigned EVT_WAKE     = 1;
  localparam logic [7:0]  OPT_RST      = 8'hFF;
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam logic [1:0]  EVT_RST      = 2'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  // --------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic          cyc;
    logic          stb;
    logic          we;
    logic [AW-1:0] adr;
    logic [3:0]    sel;
    logic [31:0]   dat;
  } wdp_wb_req_t;

  typedef struct packed {
    logic clr_tgl;  // Flips once per clear-watchdog instruction.
    logic slp_tgl;  // Flips once per sleep instruction.
    logic global_irq_enable;      // Global interrupt enable level.
  } wdp_core_t;

endpackage

// *** hw/wdp_watchdog.sv ***
// Watchdog timer with shared postscaler and a Wishbone register slave.
`timescale 1ns/1ps
module wdp_watchdog #(
  parameter int unsigned BASE_CYCLES = 2304
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Register bus
  input  wire wdp_pkg::wdp_wb_req_t wb_req_i,
  output logic                      wb_ack_o,
  output logic [31:0]               wb_dat_o,
  // Core side
  input  wire wdp_pkg::wdp_core_t   core_i,
  input  wire logic [7:0]           cfg_strap_i,
  input  wire logic                 timer_zero_tick_i,
  // Results
  output logic                      wdt_reset_o,
  output logic                      wdt_wake_o,
  output logic                      resume_inline_o,
  output logic                      timeout_status_o,
  output logic                      asleep_o,
  output logic                      timer_zero_inc_o,
  output logic                      irq_o
);

  localparam int unsigned BW = $clog2(BASE_CYCLES + 1);
  localparam logic [BW-1:0] BASE_LAST = BW'(BASE_CYCLES - 1);

  // --------------------------------------------------------------------
  // Core signal synchronisers
  // --------------------------------------------------------------------
  logic [2:0] clr_sy_q, clr_sy_d;
  logic [2:0] slp_sy_q, slp_sy_d;
  logic [1:0] gie_sy_q, gie_sy_d;
  logic       clr_evt, slp_evt, gie_s;

  // Shift the toggles through three stages and the enable level through two.
  always_comb
  begin
    clr_sy_d = {clr_sy_q[1:0], core_i.clr_tgl};
    slp_sy_d = {slp_sy_q[1:0], core_i.slp_tgl};
    gie_sy_d = {gie_sy_q[0], core_i.global_irq_enable};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clr_sy_q <= 3'h0;
      slp_sy_q <= 3'h0;
      gie_sy_q <= 2'h0;
    end
    else
    begin
      clr_sy_q <= clr_sy_d;
      slp_sy_q <= slp_sy_d;
      gie_sy_q <= gie_sy_d;
    end
  end

  // Edges are taken only between the second and third stages.
  assign clr_evt = clr_sy_q[2] ^ clr_sy_q[1];
  assign slp_evt = slp_sy_q[2] ^ slp_sy_q[1];
  assign gie_s   = gie_sy_q[1];

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  logic [7:0]  opt_q, opt_d, cfg_q, cfg_d;
  logic [1:0]  evt_q, evt_d, mask_q, mask_d;
  logic        loaded_q, loaded_d, ack_d, irq_d;
  logic [31:0] rdat_d;
  logic        acc, wr, fuse_en, assign_wdt;
  logic [2:0]  rate;
  logic        timeout;
  logic [7:0]  scl_q;
  logic        asleep_q, tos_q, inl_q;

  assign acc        = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr         = acc & wb_req_i.we & wb_req_i.sel[0];
  assign fuse_en    = loaded_q & cfg_q[wdp_pkg::CFG_EN_BIT];
  assign assign_wdt = opt_q[wdp_pkg::OPT_ASSIGN];
  assign rate       = opt_q[2:0];

  // Decode writes and reads; events set sticky bits and beat a clear.
  always_comb
  begin
    opt_d    = opt_q;
    cfg_d    = cfg_q;
    mask_d   = mask_q;
    loaded_d = 1'b1;
    evt_d    = evt_q;
    rdat_d   = 32'h0;
    ack_d    = acc;
    if (!loaded_q)
      cfg_d = cfg_strap_i;
    if (wr && wb_req_i.adr == wdp_pkg::OPT_ADR)
      opt_d = wb_req_i.dat[7:0];
    // The enable fuse can only be cleared, never set again.
    if (wr && loaded_q && wb_req_i.adr == wdp_pkg::CFG_ADR)
      cfg_d = wb_req_i.dat[7:0] & (8'hFF ^ 8'h04 | cfg_q);
    if (wr && wb_req_i.adr == wdp_pkg::MASK_ADR)
      mask_d = wb_req_i.dat[1:0];
    if (wr && wb_req_i.adr == wdp_pkg::EVT_ADR)
      evt_d = evt_d & ~wb_req_i.dat[1:0];
    if (timeout && !asleep_q)
      evt_d[wdp_pkg::EVT_RESET] = 1'b1;
    if (timeout && asleep_q)
      evt_d[wdp_pkg::EVT_WAKE] = 1'b1;
    unique case (wb_req_i.adr)
      wdp_pkg::OPT_ADR:  rdat_d = {24'h0, opt_q};
      wdp_pkg::CFG_ADR:  rdat_d = {24'h0, cfg_q};
      wdp_pkg::STAT_ADR: rdat_d = {29'h0, inl_q, asleep_q, tos_q};
      wdp_pkg::EVT_ADR:  rdat_d = {30'h0, evt_q};
      wdp_pkg::MASK_ADR: rdat_d = {30'h0, mask_q};
      wdp_pkg::CNT_ADR:  rdat_d = {24'h0, scl_q};
      default:           rdat_d = 32'h0;
    endcase
    irq_d = |(evt_d & mask_d);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      opt_q    <= wdp_pkg::OPT_RST;
      cfg_q    <= wdp_pkg::CFG_RST;
      mask_q   <= wdp_pkg::MASK_RST;
      evt_q    <= wdp_pkg::EVT_RST;
      loaded_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      irq_o    <= 1'b0;
    end
    else
    begin
      opt_q    <= opt_d;
      cfg_q    <= cfg_d;
      mask_q   <= mask_d;
      evt_q    <= evt_d;
      loaded_q <= loaded_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
      irq_o    <= irq_d;
    end
  end

  // --------------------------------------------------------------------
  // Counter, shared scaler and time-out
  // --------------------------------------------------------------------
  logic [BW-1:0] base_q, base_d;
  logic [7:0]    scl_d, wdt_last, t0_last;
  logic          clr, base_hit, t0_inc_d;
  assign clr      = clr_evt | slp_evt;
  assign base_hit = base_q == BASE_LAST;
  assign wdt_last = 8'((9'h1 << rate) - 9'h1);
  assign t0_last  = 8'((9'h2 << rate) - 9'h1);
  // The clear instructions block a time-out in the same cycle.
  assign timeout  = fuse_en & base_hit & ~clr &
                    (~assign_wdt | scl_q == wdt_last);

  // Count basic periods; the scaler serves whichever user owns it.
  always_comb
  begin
    base_d   = base_q + BW'(1);
    scl_d    = scl_q;
    t0_inc_d = 1'b0;
    if (!fuse_en || clr || base_hit)
      base_d = '0;
    if (assign_wdt)
    begin
      if (clr || timeout)
        scl_d = 8'h0;
      else if (fuse_en && base_hit)
        scl_d = scl_q + 8'h1;
    end
    else if (timer_zero_tick_i)
    begin
      t0_inc_d = scl_q == t0_last;
      scl_d    = t0_inc_d ? 8'h0 : scl_q + 8'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      base_q           <= '0;
      scl_q            <= 8'h0;
      timer_zero_inc_o <= 1'b0;
    end
    else
    begin
      base_q           <= base_d;
      scl_q            <= scl_d;
      timer_zero_inc_o <= t0_inc_d;
    end
  end

  // --------------------------------------------------------------------
  // Sleep state and time-out results
  // --------------------------------------------------------------------
  logic asleep_d, tos_d, inl_d, rst_d, wake_d;
  // Decide between reset and wake-up and track the status bit.
  always_comb
  begin
    rst_d    = timeout & ~asleep_q;
    wake_d   = timeout & asleep_q;
    asleep_d = asleep_q;
    tos_d    = tos_q;
    inl_d    = inl_q;
    if (clr_evt)
      tos_d = 1'b1;
    if (timeout)
      tos_d = 1'b0;
    if (slp_evt)
    begin
      asleep_d = 1'b1;
      inl_d    = 1'b0;
    end
    if (wake_d)
    begin
      asleep_d = 1'b0;
      inl_d    = ~gie_s;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      asleep_q    <= 1'b0;
      tos_q       <= 1'b1;
      inl_q       <= 1'b0;
      wdt_reset_o <= 1'b0;
      wdt_wake_o  <= 1'b0;
    end
    else
    begin
      asleep_q    <= asleep_d;
      tos_q       <= tos_d;
      inl_q       <= inl_d;
      wdt_reset_o <= rst_d;
      wdt_wake_o  <= wake_d;
    end
  end

  // Status outputs mirror their registers.
  assign timeout_status_o = tos_q;
  assign asleep_o         = asleep_q;
  assign resume_inline_o  = inl_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tout_awake;
    timeout && !asleep_q;
  endsequence
  sequence s_tout_asleep;
    timeout && asleep_q;
  endsequence

  property p_count_runs;
    fuse_en && !clr && !base_hit |=> base_q == $past(base_q) + BW'(1);
  endproperty
  a_count_runs: assert property (p_count_runs)
    else $error("Watchdog count did not advance.");

  property p_reset_awake;
    s_tout_awake |=> wdt_reset_o && !wdt_wake_o ##1 !wdt_reset_o;
  endproperty
  a_reset_awake: assert property (p_reset_awake)
    else $error("Awake time-out gave no single reset pulse.");

  property p_wake_sleep;
    s_tout_asleep |=> wdt_wake_o && !wdt_reset_o && !asleep_q;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("Sleeping time-out did not wake the device.");

  property p_tos_clear;
    timeout |=> !timeout_status_o;
  endproperty
  a_tos_clear: assert property (p_tos_clear)
    else $error("Time-out left the status bit set.");

  property p_fuse_off;
    !fuse_en |=> !wdt_reset_o && !wdt_wake_o;
  endproperty
  a_fuse_off: assert property (p_fuse_off)
    else $error("Disabled watchdog produced an event.");

  property p_ratio;
    assign_wdt && base_hit && scl_q != wdt_last
      |=> !wdt_reset_o && !wdt_wake_o;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("Time-out came before the scaler ratio.");

  property p_clear;
    clr |=> base_q == '0 && (!$past(assign_wdt) || scl_q == 8'h0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("Clear did not zero the count.");

  property p_keep_opt;
    clr_evt && !wr |=> opt_q == $past(opt_q);
  endproperty
  a_keep_opt: assert property (p_keep_opt)
    else $error("Clear changed the scaler setting.");

  property p_inline;
    s_tout_asleep |=> resume_inline_o == !$past(gie_s);
  endproperty
  a_inline: assert property (p_inline)
    else $error("Resume mode does not follow interrupt enable.");

  property p_share;
    !assign_wdt && timer_zero_tick_i && scl_q == t0_last
      |=> timer_zero_inc_o;
  endproperty
  a_share: assert property (p_share)
    else $error("Scaler did not serve Timer0.");

endmodule // wdp_watchdog

// *** tb/wdp_core_model.sv ***
// Behavioural processor core issuing clear-watchdog and sleep.
`timescale 1ns/1ps
module wdp_core_model (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Bench requests
  input  wire logic          clr_req_i,
  input  wire logic          slp_req_i,
  input  wire logic          gie_i,
  // Core link
  output wdp_pkg::wdp_core_t core_o
);
  // Each instruction flips its toggle once; callers keep them spaced.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      core_o <= '0;
    else
    begin
      core_o.clr_tgl <= core_o.clr_tgl ^ clr_req_i;
      core_o.slp_tgl <= core_o.slp_tgl ^ slp_req_i;
      core_o.global_irq_enable     <= gie_i;
    end
  end
endmodule // wdp_core_model

// *** tb/watchdog_timer_with_postscaler_tb_top.sv ***
// Self-checking bench for the watchdog with postscaler.
`timescale 1ns/1ps
module watchdog_timer_with_postscaler_tb_top;
  logic                 clk_i, rst_i, clr_req, slp_req, global_irq_enable, tick;
  logic                 ack, rst_o, wake, inl, tos, slp, inc, irq;
  logic [7:0]           strap;
  logic [31:0]          rdat, rd;
  wdp_pkg::wdp_wb_req_t req;
  wdp_pkg::wdp_core_t   core;
  int                   errors = 0, num_checks = 0;
  int                   n_rst = 0, n_wake = 0, n_inc = 0;

  wdp_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .clr_req_i(clr_req),
    .slp_req_i(slp_req), .gie_i(global_irq_enable), .core_o(core));

  wdp_watchdog #(.BASE_CYCLES(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat), .core_i(core),
    .cfg_strap_i(strap), .timer_zero_tick_i(tick), .wdt_reset_o(rst_o),
    .wdt_wake_o(wake), .resume_inline_o(inl), .timeout_status_o(tos),
    .asleep_o(slp), .timer_zero_inc_o(inc), .irq_o(irq));

  // Clock of 8 ns.
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Pulse counters, sampled mid-cycle where outputs have settled.
  always @(negedge clk_i)
  begin
    n_rst  += int'(rst_o === 1'b1);
    n_wake += int'(wake === 1'b1);
    n_inc  += int'(inc === 1'b1);
  end

  task automatic wrap_up;
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h0, d}};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = rdat;
    req <= '0;
    chk(n < 20, 1'b1, "bus ack");
  endtask

  task automatic rdr(input logic [15:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e}, "register read");
  endtask

  // One instruction from the core model: 1 sleep, 0 clear-watchdog.
  task automatic instr(input logic s);
    @(posedge clk_i);
    if (s)
      slp_req <= 1'b1;
    else
      clr_req <= 1'b1;
    @(posedge clk_i);
    {clr_req, slp_req} <= 2'b00;
    repeat (4) @(posedge clk_i);
  endtask

  // Waits a bounded time for a wake (w=1) or reset (w=0) pulse.
  task automatic wait_evt(input logic w, input int lim);
    int b, n;
    b = w ? n_wake : n_rst;
    for (n = 0; n < lim && (w ? n_wake : n_rst) == b; n++)
      @(posedge clk_i);
    chk(n < lim, 1'b1, "event in time");
  endtask

  task automatic t_reset;
    rdr(wdp_pkg::OPT_ADR, 8'hFF);
    rdr(wdp_pkg::STAT_ADR, 8'h01);
    rdr(wdp_pkg::EVT_ADR, 8'h00);
    rdr(wdp_pkg::MASK_ADR, 8'h00);
    rdr(wdp_pkg::CFG_ADR, 8'h04);
    rdr(16'h0100, 8'h00);
  endtask

  task automatic t_run;
    int b;
    wb(1'b1, wdp_pkg::MASK_ADR, 8'h03);
    // Clear while the scaler still serves the watchdog, so it starts at zero.
    instr(1'b0);
    wb(1'b1, wdp_pkg::OPT_ADR, 8'h00);
    wait_evt(1'b0, 30);
    chk(tos, 1'b0, "status after reset");
    chk(irq, 1'b1, "irq raised");
    rdr(wdp_pkg::EVT_ADR, 8'h01);
    b = n_inc;
    repeat (4)
    begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      @(posedge clk_i);
    end
    repeat (2) @(posedge clk_i);
    chk(n_inc - b, 2, "timer zero ratio");
    wb(1'b1, wdp_pkg::OPT_ADR, 8'h0F);
    instr(1'b0);
    wb(1'b1, wdp_pkg::EVT_ADR, 8'h03);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0, "irq cleared");
    chk(tos, 1'b1, "status after clear");
  endtask

  // Assigned scaler at rate 2 gives four 8-cycle periods.
  task automatic t_clr;
    int b;
    wb(1'b1, wdp_pkg::OPT_ADR, 8'h0A);
    instr(1'b0);
    b = n_rst;
    repeat (8) instr(1'b0);
    chk(n_rst, b, "no reset while cleared");
    rdr(wdp_pkg::OPT_ADR, 8'h0A);
    repeat (16) @(posedge clk_i);
    chk(n_rst, b, "no early time-out");
    rdr(wdp_pkg::CNT_ADR, 8'h02);
    wait_evt(1'b0, 24);
  endtask

  task automatic t_sleep;
    int b;
    global_irq_enable <= 1'b0;
    instr(1'b1);
    b = n_rst;
    chk(slp, 1'b1, "asleep");
    wait_evt(1'b1, 50);
    @(posedge clk_i);
    chk(n_rst, b, "no reset in sleep");
    chk(slp, 1'b0, "awake");
    chk(tos, 1'b0, "status after wake");
    chk(inl, 1'b1, "resume in-line");
    rdr(wdp_pkg::EVT_ADR, 8'h03);
    // A second sleep with interrupts enabled must not resume in-line.
    global_irq_enable <= 1'b1;
    instr(1'b1);
    chk(inl, 1'b0, "in-line cleared by sleep");
    wait_evt(1'b1, 50);
    @(posedge clk_i);
    chk(inl, 1'b0, "resume by vector");
  endtask

  task automatic t_fuse;
    int b;
    rst_i <= 1'b1;
    strap <= 8'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdr(wdp_pkg::STAT_ADR, 8'h01);
    wb(1'b1, wdp_pkg::OPT_ADR, 8'h00);
    wb(1'b1, wdp_pkg::CFG_ADR, 8'hFF);
    rdr(wdp_pkg::CFG_ADR, 8'hFB);
    b = n_rst + n_wake;
    repeat (100) @(posedge clk_i);
    chk(n_rst + n_wake, b, "fuse off");
  endtask

  initial
  begin
    {rst_i, strap, req, clr_req, slp_req, global_irq_enable, tick} = {1'b1, 8'h04, 59'h0};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_run();
    t_clr();
    t_sleep();
    t_fuse();
    wrap_up();
  end

  // Hang guard, well beyond the fewer than 500 cycles the run needs.
  initial
  begin
    #40000;
    errors++;
    wrap_up();
  end
endmodule // watchdog_timer_with_postscaler_tb_top
